// >>> src/irq_en_regs.vh
`ifndef IRQ_EN_REGS_VH
`define IRQ_EN_REGS_VH
`define ADDR_SOFT_RESET 8'h14
`define ADDR_IRQ_EN0 8'h16
`define ADDR_IRQ_EN1 8'h17
`define ADDR_IRQ_EN2 8'h18
`define SOFT_RESET_KEY 8'hB6
`define IRQ_EN0_RESET 8'h00
`define IRQ_EN1_RESET 8'h00
`define IRQ_EN2_RESET 8'h00
`define IRQ_EN0_MASK 8'hF7
`define IRQ_EN1_MASK 8'h7F
`define IRQ_EN2_MASK 8'h0F
`define READ_UNMAPPED 8'h00
`define SOFT_RESET_DELAY 8'h10
`define SEL_BIT 3
`define DELAY_IDLE 8'h00
`define DELAY_STEP 8'h01
`define FLAGS_CLEAR 8'h00
`define SLO_FLAGS_CLEAR 3'h0
`define FLAT_BIT 7
`define ORIENT_BIT 6
`define S_TAP_BIT 5
`define D_TAP_BIT 4
`define RSV0_BIT 3
`define AXIS_Z_BIT 2
`define AXIS_Y_BIT 1
`define AXIS_X_BIT 0
`define RSV1_BIT 7
`define FWM_BIT 6
`define FFULL_BIT 5
`define DRDY_BIT 4
`define LOW_BIT 3
`define EV_FLAT 3
`define EV_ORIENT 2
`define EV_S_TAP 1
`define EV_D_TAP 0
`define EV_FWM 2
`define EV_FFULL 1
`define EV_DRDY 0
`endif

// >>> src/irq_enable_regs.v
`timescale 1ns/10ps
`default_nettype none
`include "irq_en_regs.vh"
module irq_enable_regs #(
  parameter RESET_DELAY = `SOFT_RESET_DELAY
) (
  // clock and reset
  input wire clk_in,
  input wire rst_in,
  // register port from the serial interface
  input wire wr_en_in,
  input wire rd_en_in,
  input wire [7:0] addr_in,
  input wire [7:0] wdata_in,
  output reg [7:0] rdata_out,
  // raw engine events
  input wire [3:0] ev_grp0_in,
  input wire [2:0] ev_slope_in,
  input wire [2:0] ev_fifo_in,
  input wire ev_low_in,
  input wire [2:0] ev_high_in,
  input wire [2:0] ev_slo_no_mot_in,
  // gated engine flags and configuration
  output reg [7:0] flags0_out,
  output reg [7:0] flags1_out,
  output reg [2:0] slo_no_mot_flags_out,
  output reg no_motion_sel_out,
  // soft reset request to the rest of the device
  output reg cfg_reset_out
);

  // address decode shared by the key, write and read paths
  function addr_match;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_match = (addr == target);
    end
  endfunction

  // register state
  reg [7:0] en0_r;
  reg [7:0] en1_r;
  reg [7:0] en2_r;
  reg pending_r;
  reg [7:0] delay_r;

  // decoded accesses and gated flag values
  wire key_hit;
  wire [7:0] delay_init;
  reg [7:0] flags0_nxt;
  reg [7:0] flags1_nxt;
  reg [2:0] slo_flags_nxt;

  // counter is 8 bits wide, so a delay above 255 is cut on purpose
  assign delay_init = RESET_DELAY[7:0];

  // no power-mode gating, so the key works in suspend too
  assign key_hit = wr_en_in && addr_match(addr_in, `ADDR_SOFT_RESET) &&
    (wdata_in == `SOFT_RESET_KEY);

  // delayed restore; the pulse also clears this bank
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pending_r <= 1'h0;
      delay_r <= `DELAY_IDLE;
      cfg_reset_out <= 1'h0;
    end
    else
    begin
      cfg_reset_out <= 1'h0;
      // a second key while counting is dropped, not restarted
      if (key_hit && !pending_r)
      begin
        pending_r <= 1'h1;
        delay_r <= delay_init;
      end
      else if (pending_r)
      begin
        if (delay_r == `DELAY_IDLE)
        begin
          pending_r <= 1'h0;
          cfg_reset_out <= 1'h1;
        end
        else
        begin
          delay_r <= delay_r - `DELAY_STEP;
        end
      end
    end
  end

  // enable registers; reserved bits are held at zero
  always @(posedge clk_in)
  begin
    if (rst_in || cfg_reset_out)
    begin
      en0_r <= `IRQ_EN0_RESET;
      en1_r <= `IRQ_EN1_RESET;
      en2_r <= `IRQ_EN2_RESET;
    end
    else if (wr_en_in)
    begin
      if (addr_match(addr_in, `ADDR_IRQ_EN0))
        en0_r <= wdata_in & `IRQ_EN0_MASK;
      else if (addr_match(addr_in, `ADDR_IRQ_EN1))
        en1_r <= wdata_in & `IRQ_EN1_MASK;
      else if (addr_match(addr_in, `ADDR_IRQ_EN2))
        en2_r <= wdata_in & `IRQ_EN2_MASK;
    end
  end

  // read mux; soft reset address reads zero
  always @(posedge clk_in)
  begin
    if (rst_in)
      rdata_out <= `READ_UNMAPPED;
    else if (rd_en_in)
    begin
      if (addr_match(addr_in, `ADDR_IRQ_EN0))
        rdata_out <= en0_r;
      else if (addr_match(addr_in, `ADDR_IRQ_EN1))
        rdata_out <= en1_r;
      else if (addr_match(addr_in, `ADDR_IRQ_EN2))
        rdata_out <= en2_r;
      else
        rdata_out <= `READ_UNMAPPED;
    end
  end

  // per-bit gating; reserved positions are forced low
  always @*
  begin
    flags0_nxt = `FLAGS_CLEAR;
    flags1_nxt = `FLAGS_CLEAR;
    slo_flags_nxt = `SLO_FLAGS_CLEAR;
    // group 0: feature engines and slope axes
    flags0_nxt[`FLAT_BIT] = ev_grp0_in[`EV_FLAT] & en0_r[`FLAT_BIT];
    flags0_nxt[`ORIENT_BIT] = ev_grp0_in[`EV_ORIENT] &
      en0_r[`ORIENT_BIT];
    flags0_nxt[`S_TAP_BIT] = ev_grp0_in[`EV_S_TAP] &
      en0_r[`S_TAP_BIT];
    flags0_nxt[`D_TAP_BIT] = ev_grp0_in[`EV_D_TAP] &
      en0_r[`D_TAP_BIT];
    flags0_nxt[`AXIS_Z_BIT] = ev_slope_in[`AXIS_Z_BIT] &
      en0_r[`AXIS_Z_BIT];
    flags0_nxt[`AXIS_Y_BIT] = ev_slope_in[`AXIS_Y_BIT] &
      en0_r[`AXIS_Y_BIT];
    flags0_nxt[`AXIS_X_BIT] = ev_slope_in[`AXIS_X_BIT] &
      en0_r[`AXIS_X_BIT];
    // group 1: fifo, data ready, low-g and high-g axes
    flags1_nxt[`FWM_BIT] = ev_fifo_in[`EV_FWM] & en1_r[`FWM_BIT];
    flags1_nxt[`FFULL_BIT] = ev_fifo_in[`EV_FFULL] & en1_r[`FFULL_BIT];
    flags1_nxt[`DRDY_BIT] = ev_fifo_in[`EV_DRDY] & en1_r[`DRDY_BIT];
    flags1_nxt[`LOW_BIT] = ev_low_in & en1_r[`LOW_BIT];
    flags1_nxt[`AXIS_Z_BIT] = ev_high_in[`AXIS_Z_BIT] &
      en1_r[`AXIS_Z_BIT];
    flags1_nxt[`AXIS_Y_BIT] = ev_high_in[`AXIS_Y_BIT] &
      en1_r[`AXIS_Y_BIT];
    flags1_nxt[`AXIS_X_BIT] = ev_high_in[`AXIS_X_BIT] &
      en1_r[`AXIS_X_BIT];
    // group 2: slow/no-motion axes
    slo_flags_nxt[`AXIS_Z_BIT] = ev_slo_no_mot_in[`AXIS_Z_BIT] &
      en2_r[`AXIS_Z_BIT];
    slo_flags_nxt[`AXIS_Y_BIT] = ev_slo_no_mot_in[`AXIS_Y_BIT] &
      en2_r[`AXIS_Y_BIT];
    slo_flags_nxt[`AXIS_X_BIT] = ev_slo_no_mot_in[`AXIS_X_BIT] &
      en2_r[`AXIS_X_BIT];
  end

  // gate engine events by their enables
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      flags0_out <= `FLAGS_CLEAR;
      flags1_out <= `FLAGS_CLEAR;
      slo_no_mot_flags_out <= `SLO_FLAGS_CLEAR;
      no_motion_sel_out <= 1'h0;
    end
    else
    begin
      // levels, not sticky: a flag drops on the clock after its event does
      flags0_out <= flags0_nxt;
      flags1_out <= flags1_nxt;
      slo_no_mot_flags_out <= slo_flags_nxt;
      no_motion_sel_out <= en2_r[`SEL_BIT];
    end
  end

endmodule // irq_enable_regs
`default_nettype wire

// >>> tb/host.sv
`timescale 1ns/10ps
`default_nettype none
// host side; rewriting settings after a soft reset is up to the caller
module host (
  input wire logic clk_in,
  output logic wr_out = 0, rd_out = 0,
  output logic [7:0] a_out = 0, d_out = 0);
  // one access per call; released lines show inverted values, not the last
  task acc(input logic w, input logic [7:0] ad, da);
    @(posedge clk_in) #1 {wr_out, rd_out, a_out, d_out} = {w, !w, ad, da};
    @(posedge clk_in) #1 {wr_out, rd_out, a_out, d_out} = {2'b0, ~ad, ~da};
  endtask
endmodule // host
`default_nettype wire

// >>> tb/irq_props.sv
`timescale 1ns/10ps
`default_nettype none
module irq_props #(parameter int RESET_DELAY = 2) (
  input wire clk_in, rst_in, wr_en_in, rd_en_in, cfg_reset_out,
  input wire no_motion_sel_out,
  input wire [7:0] addr_in, wdata_in, rdata_out, flags0_out, flags1_out,
  input wire [2:0] slo_no_mot_flags_out);
  localparam int DL = RESET_DELAY + 2;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // key write to pulse; a key while pending is not covered here
  property p_key;
    wr_en_in && addr_in == 8'h14 && wdata_in == 8'hB6 |-> ##DL cfg_reset_out;
  endproperty
  property p_pls; cfg_reset_out |=> !cfg_reset_out; endproperty
  property p_rd; rd_en_in && addr_in == 8'h14 |=> !rdata_out; endproperty
  property p_rd0; rd_en_in && addr_in == 8'h16 |=> !rdata_out[3]; endproperty
  property p_rd1; rd_en_in && addr_in == 8'h17 |=> !rdata_out[7]; endproperty
  property p_sel;
    wr_en_in && addr_in == 8'h18 && !cfg_reset_out |=> ##1
      no_motion_sel_out == $past(wdata_in[3], 2);
  endproperty
  property p_clr;
    cfg_reset_out |=> ##1 (flags0_out == 8'h00 && flags1_out == 8'h00 &&
      slo_no_mot_flags_out == 3'h0);
  endproperty
  a_key: assert property (p_key) else $error("no pulse");
  a_pls: assert property (p_pls) else $error("long pulse");
  a_rd: assert property (p_rd) else $error("key read");
  a_rd0: assert property (p_rd0) else $error("group0 reserved set");
  a_rd1: assert property (p_rd1) else $error("group1 reserved set");
  a_sel: assert property (p_sel) else $error("select not taken");
  a_clr: assert property (p_clr) else $error("flags after reset");
  c_pls: cover property (cfg_reset_out);
  c_rd: cover property (rd_en_in && addr_in == 8'h14);
  c_wr: cover property (wr_en_in && addr_in == 8'h18);
endmodule // irq_props
bind irq_enable_regs irq_props #(.RESET_DELAY(RESET_DELAY)) irq_props_i (
  .clk_in, .rst_in, .wr_en_in, .rd_en_in, .cfg_reset_out, .addr_in,
  .wdata_in, .rdata_out, .no_motion_sel_out, .flags0_out, .flags1_out,
  .slo_no_mot_flags_out);
`default_nettype wire

// >>> tb/softreset_and_irq_enable_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module softreset_and_irq_enable_regs_tb;
  logic clk_in = 0, rst_in = 1, e = 0, wr_en_in, rd_en_in, sel, cfg_reset_out;
  logic [7:0] addr_in, wdata_in, rdata_out, flags0_out, flags1_out, n = 0;
  logic [2:0] sflags;
  int failures = 0, comparisons = 0, cyc = 0;
  // address, written, read back
  logic [7:0] rows [5][3] = '{'{8'h16, 8'hFF, 8'hF7}, '{8'h17, 8'hFF, 8'h7F},
    '{8'h18, 8'hFF, 8'h0F}, '{8'h14, 8'h00, 8'h00}, '{8'h15, 8'hFF, 8'h00}};
  host host_i (.clk_in, .wr_out(wr_en_in), .rd_out(rd_en_in),
    .a_out(addr_in), .d_out(wdata_in));
  irq_enable_regs #(.RESET_DELAY(2)) irq_enable_regs_i (.clk_in, .rst_in,
    .wr_en_in, .rd_en_in, .addr_in, .wdata_in, .rdata_out, .ev_low_in(e),
    .ev_grp0_in({4{e}}), .ev_slope_in({3{e}}), .ev_fifo_in({3{e}}),
    .ev_high_in({3{e}}), .ev_slo_no_mot_in({3{e}}), .flags0_out, .flags1_out,
    .slo_no_mot_flags_out(sflags), .no_motion_sel_out(sel), .cfg_reset_out);
  initial forever #50 clk_in = ~clk_in;
  // hang guard; the run needs about 50 cycles
  always @(posedge clk_in) if (++cyc == 900) results();
  task chk(input string s, input logic [7:0] x, g);
    comparisons++;
    failures += g !== x;
    if (g !== x) $display("[ERR] %s exp %h got %h", s, x, g);
  endtask
  task results;
    failures += cyc >= 900;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (4) @(posedge clk_in);
    #1 rst_in = 0;
    host_i.acc(0, 8'h16, 0);
    chk("reset", 0, rdata_out);
    foreach (rows[i])
    begin
      host_i.acc(1, rows[i][0], rows[i][1]);
      host_i.acc(0, rows[i][0], 0);
      chk("reg", rows[i][2], rdata_out);
    end
    e = 1;
    @(posedge clk_in) #1 chk("flags", 8'h7F, flags1_out);
    chk("sel", 1, sel);
    chk("flags0", 8'hF7, flags0_out);
    chk("slo", 8'h07, {5'h00, sflags});
    // a wrong key must not start the countdown
    host_i.acc(1, 8'h14, 8'hB5);
    repeat (6) @(posedge clk_in) #1 n += cfg_reset_out;
    chk("nonkey", 0, n);
    host_i.acc(1, 8'h14, 8'hB6);
    repeat (6) @(posedge clk_in) #1 n += cfg_reset_out;
    chk("pulse", 1, n);
    host_i.acc(0, 8'h16, 0);
    chk("cleared", 0, rdata_out);
    chk("gated", 0, flags0_out);
    chk("gated2", 0, {5'h00, sflags});
    // reset again in mid-run with an engine enabled
    host_i.acc(1, 8'h17, 8'hFF);
    rst_in = 1;
    repeat (2) @(posedge clk_in);
    #1 rst_in = 0;
    host_i.acc(0, 8'h17, 0);
    chk("rst", 0, rdata_out);
    chk("rstflags", 0, flags1_out);
    results();
  end
endmodule // softreset_and_irq_enable_regs_tb
`default_nettype wire
